// ### bench/sam_axis_props.sv
`timescale 1ns/10ps
// ==========
// port checker
module sam_axis_props
  import sam_pkg::*;
(
  input wire logic        core_clk_i,
  input wire logic        sys_rst_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hsel_i,
  input wire logic        hready_i,
  input wire logic        stop_error_i,
  input wire logic        vel_zero_i,
  input wire logic        battery_alarm_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        servo_power_on_signal_o,
  input wire logic        battery_alarm_o,
  input wire logic        scurve_o,
  input wire logic        eot_check_o,
  input wire logic [31:0] jog_acc_o,
  input wire logic [31:0] pos_loop_res_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic       take_w;
  logic       rd_take;
  logic [3:0] wr_q;
  // accepted address phases
  assign take_w  = hsel_i && hready_i && htrans_i[1];
  assign rd_take = take_w && !hwrite_i;
  // history of recent write address phases
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) wr_q <= 4'h0;
    else wr_q <= {wr_q[2:0], take_w && hwrite_i};
  end
  sequence moving_s;
    servo_power_on_signal_o && !vel_zero_i;
  endsequence
  sequence cfg_move_s;
    $changed(scurve_o) || $changed(eot_check_o);
  endsequence
  hready_ok_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  acc_floor_a: assert property (jog_acc_o >= ACC_FLOOR)
    else $error("manual accel below floor");
  res_table_a: assert property (pos_loop_res_o inside
    {32'h2000, 32'h4000, 32'h8000, 32'h10000})
    else $error("resolution not in table");
  battery_gate_a: assert property (
    battery_alarm_o |-> $past(battery_alarm_i))
    else $error("alarm out without alarm in");
  drive_hold_a: assert property (moving_s |=> servo_power_on_signal_o)
    else $error("drive dropped while still moving");
  drive_start_a: assert property (
    $rose(servo_power_on_signal_o) |-> !$past(stop_error_i, 2))
    else $error("drive rose during stop error");
  cfg_change_a: assert property (cfg_move_s |-> wr_q != 4'h0)
    else $error("profile or limit mode changed without write");
  rdata_stand_a: assert property ($changed(hrdata_o) |-> $past(rd_take))
    else $error("read data moved without read");
endmodule

bind sam_axis sam_axis_props i_props (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .htrans_i(htrans_i),
  .hwrite_i(hwrite_i), .hsel_i(hsel_i), .hready_i(hready_i),
  .stop_error_i(stop_error_i), .vel_zero_i(vel_zero_i),
  .battery_alarm_i(battery_alarm_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .servo_power_on_signal_o(servo_power_on_signal_o),
  .battery_alarm_o(battery_alarm_o), .scurve_o(scurve_o),
  .eot_check_o(eot_check_o), .jog_acc_o(jog_acc_o),
  .pos_loop_res_o(pos_loop_res_o));

// ### bench/sam_drive_model.sv
`timescale 1ns/10ps
// ==========
// drive and encoder model
module sam_drive_model #(
  parameter int DECEL = 20
) (
  input  wire logic core_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic drive_on_i,
  input  wire logic move_i,
  output logic      vel_zero_o
);
  logic [7:0] ramp_q;
  // speed ramps down over DECEL cycles once motion stops
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) ramp_q <= 8'h00;
    else if (move_i && drive_on_i) ramp_q <= 8'(DECEL);
    else if (ramp_q != 8'h00) ramp_q <= ramp_q - 8'h01;
  end
  assign vel_zero_o = (ramp_q == 8'h00);
endmodule

// ### bench/test_servo_axis_motion_config.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  fail_count++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module test_servo_axis_motion_config;
  import sam_pkg::*;
  logic        clk, rst, hsel, hwrite, stop, batt, wrap_hi, wrap_lo, move;
  logic        vzero, hrdy, hresp, drv, revc, batto, scurve, travel_limit, irq;
  logic [1:0]  htrans;
  logic [7:0]  gain;
  logic [31:0] haddr, hwdata, hrdata, jvel, jacc, tpos, tneg, res;
  logic [31:0] rdv, seed, v;
  int          fail_count, checks_done, i;
  // ==========
  // design and far side
  sam_axis i_dut (.core_clk_i(clk), .sys_rst_i(rst), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010),
    .hwdata_i(hwdata), .hsel_i(hsel), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .stop_error_i(stop),
    .vel_zero_i(vzero), .battery_alarm_i(batt), .pos_wrap_hi_i(wrap_hi),
    .pos_wrap_lo_i(wrap_lo), .servo_power_on_signal_o(drv),
    .rev_comp_en_o(revc), .speed_loop_gain_o(gain), .battery_alarm_o(batto),
    .scurve_o(scurve), .eot_check_o(travel_limit), .travel_limit_pos_o(tpos),
    .travel_limit_neg_o(tneg), .jog_vel_o(jvel), .jog_acc_o(jacc),
    .pos_loop_res_o(res), .irq_o(irq));
  sam_drive_model i_drive (.core_clk_i(clk), .sys_rst_i(rst),
    .drive_on_i(drv), .move_i(move), .vel_zero_o(vzero));
  // ==========
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_acc(input logic [31:0] a);
    return (a < 32'h20) ? 32'h20 : a;
  endfunction
  function automatic logic [7:0] exp_gain(input logic [31:0] g);
    return (g < 32'h100) ? g[7:0] : 8'h00;
  endfunction
  task automatic wait_rdy;
    do begin
      @(posedge clk);
    end while (hrdy !== 1'b1);
  endtask
  // one single ahb transfer, address then data phase
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
    // spare edge: outputs launched two edges after the write settle
    repeat (3) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] t;
    bus(1'b1, a, d, t);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0, rdv);
  endtask
  task automatic tune(input logic [31:0] a, b, input logic e);
    wr(OFF_TUNE1, a);
    wr(OFF_TUNE2, b);
    rd(OFF_STATUS);
    `CHK("tune err", e, rdv[SB_TUNEERR]);
  endtask
  // let the axis stop and expect the drive to follow
  task automatic halt_check;
    move <= 1'b0;
    `CHK("drive held", 1'b1, drv);
    for (int n = 0; n < 40 && vzero !== 1'b1; n++) @(posedge clk);
    repeat (4) @(posedge clk);
    `CHK("drive off", 1'b0, drv);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ==========
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    repeat (6000) @(posedge clk);
    fail_count++;
    stop_test();
  end
  // ==========
  // tests
  initial begin
    {rst, hsel, hwrite, stop, batt, wrap_hi, wrap_lo, move} = 8'h80;
    {htrans, haddr, hwdata} = '0;
    seed = 32'hfae3e3d4;
    fail_count = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_DLY);
    `CHK("delay", 32'h64, rdv);
    rd(OFF_GAIN);
    `CHK("gain reg", 32'h10, rdv);
    `CHK("jog vel", 32'h3e8, jvel);
    `CHK("jog acc", 32'h2710, jacc);
    `CHK("res", 32'h2000, res);
    `CHK("modes", 2'b00, {scurve, travel_limit});
    tune(32'h0, 32'h0, 1'b0);
    rd(8'h80);
    `CHK("unmapped", 32'h0, rdv);
    $display("test defaults done");
    wr(OFF_CTRL, 32'h2);
    for (i = 0; i < 8; i++) begin
      seed = lfsr_next(seed);
      v = (i == 0) ? 32'hff : (i == 1) ? 32'h100 : {23'h0, seed[8:0]};
      wr(OFF_GAIN, v);
      `CHK("gain", exp_gain(v), gain);
      rd(OFF_STATUS);
      `CHK("gain err", v[8], rdv[SB_CFGERR]);
    end
    wr(OFF_CTRL, 32'h0);
    `CHK("analog gain", 8'h00, gain);
    for (i = 0; i < 8; i++) begin
      seed = lfsr_next(seed);
      v = (i < 3) ? 32'(32'h1f + i) : (i == 3) ? 32'h0 : {25'h0, seed[6:0]};
      wr(OFF_JOGA, v);
      `CHK("jog acc", exp_acc(v), jacc);
      wr(OFF_JOGV, seed);
      `CHK("jog vel", seed, jvel);
    end
    $display("test gain and manual move done");
    for (i = 0; i < 16; i++) begin
      wr(OFF_CTRL, {25'h0, i[3:0], 3'b000});
      `CHK("scurve", i[0], scurve);
      `CHK("rev comp", !i[1], revc);
      `CHK("eot", i[3:2] == 2'b01, travel_limit);
      rd(OFF_STATUS);
      `CHK("reserved", i[3], rdv[SB_RSVMODE]);
    end
    wr(OFF_HILIM, 32'h64);
    wr(OFF_LOLIM, 32'hffffff9c);
    wr(OFF_PEOT, 32'hc8);
    wr(OFF_NEOT, 32'hffffffce);
    wr(OFF_CTRL, 32'h20);
    `CHK("pos lim", 32'h64, tpos);
    `CHK("neg lim", 32'hffffffce, tneg);
    wr(OFF_CTRL, 32'h30);
    `CHK("pos lim", 32'h64, tpos);
    `CHK("neg lim", 32'hffffff9c, tneg);
    $display("test modes and limits done");
    wr(OFF_CTRL, 32'h2);
    for (i = 0; i < 5; i++) begin
      tune(32'h10000 | i, 32'h0, i == 4);
      if (i < 4) `CHK("res", 32'h2000 << i, res);
    end
    tune(32'h50000, 32'h50000, 1'b1);
    tune(32'h400000, 32'h0, 1'b1);
    tune(32'h0, 32'hff0000, 1'b0);
    tune(32'h0, 32'h10003, 1'b0);
    `CHK("res", 32'h10000, res);
    tune(32'h0, 32'h0, 1'b0);
    `CHK("res", 32'h2000, res);
    $display("test tuning done");
    for (i = 0; i < 4; i++) begin
      wr(OFF_CTRL, 32'(i << 1));
      batt <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("battery", i == 3, batto);
      batt <= 1'b0;
    end
    wr(OFF_IRQ_CLR, 32'hf);
    wr(OFF_IRQ_EN, 32'h1);
    `CHK("irq idle", 1'b0, irq);
    batt <= 1'b1;
    @(posedge clk);
    batt <= 1'b0;
    rd(OFF_IRQ_ST);
    `CHK("alarm event", 1'b1, rdv[IB_BATTERY]);
    `CHK("irq", 1'b1, irq);
    wr(OFF_IRQ_EN, 32'h0);
    `CHK("irq masked", 1'b0, irq);
    wr(OFF_IRQ_EN, 32'h1);
    `CHK("irq", 1'b1, irq);
    wr(OFF_IRQ_CLR, 32'h1);
    `CHK("irq cleared", 1'b0, irq);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_IRQ_CLR, 32'hf);
    wrap_hi <= 1'b1;
    @(posedge clk);
    wrap_hi <= 1'b0;
    rd(OFF_IRQ_ST);
    `CHK("rollover", 1'b1, rdv[IB_ROLL]);
    wr(OFF_CTRL, 32'h20);
    wr(OFF_IRQ_CLR, 32'hf);
    wrap_lo <= 1'b1;
    @(posedge clk);
    wrap_lo <= 1'b0;
    rd(OFF_IRQ_ST);
    `CHK("rollover", 1'b0, rdv[IB_ROLL]);
    $display("test alarms and interrupts done");
    wr(OFF_DLY, 32'h0);
    wr(OFF_CTRL, 32'h1);
    `CHK("drive on", 1'b1, drv);
    move <= 1'b1;
    wr(OFF_CTRL, 32'h0);
    halt_check();
    rd(OFF_IRQ_ST);
    `CHK("drive off event", 1'b1, rdv[IB_DRIVEOFF]);
    wr(OFF_CTRL, 32'h1);
    move <= 1'b1;
    stop <= 1'b1;
    repeat (3) @(posedge clk);
    halt_check();
    stop <= 1'b0;
    wr(OFF_DLY, 32'h64);
    wr(OFF_CTRL, 32'h1);
    wr(OFF_CTRL, 32'h0);
    repeat (300) @(posedge clk);
    `CHK("drive delay", 1'b1, drv);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("drive reset", 1'b0, drv);
    $display("test drive done");
    stop_test();
  end
endmodule

// ### core/sam_axis.sv
`timescale 1ns/10ps
// Contract
// - backlash compensation active only in standard mode, never follower
// - drive enable held for delay ms after velocity reaches zero on stop
// - speed gain 0..255, default 16, used only for digital servos
// - battery alarms reported only for absolute feedback in digital mode
// - manual acceleration used for manual moves and programs, 10000
// - effective manual acceleration in counts never below 32
// - linear or jerk-limited profile; jerk-limited takes twice time
// - continuous mode ignores travel limits, rolls over at count limits
// - linear mode enforces travel limits clamped to rollover limits
// - both rotary mode codes are reserved, no defined behaviour
// - follower sets travel limits to the rollover limits
// - second selector 0..255, value signed 16 bit, both default 0
// - selector 0 unused; selector 1 selects position loop resolution
// - resolution data 0..3 gives 8192 to 65536 counts per rev; code applies it in digital mode only, analog stays 8192
module sam_axis (
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hsel_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        stop_error_i,
  input  wire logic        vel_zero_i,
  input  wire logic        battery_alarm_i,
  input  wire logic        pos_wrap_hi_i,
  input  wire logic        pos_wrap_lo_i,
  output logic             servo_power_on_signal_o,
  output logic             rev_comp_en_o,
  output logic [7:0]       speed_loop_gain_o,
  output logic             battery_alarm_o,
  output logic             scurve_o,
  output logic             eot_check_o,
  output logic [31:0]      travel_limit_pos_o,
  output logic [31:0]      travel_limit_neg_o,
  output logic [31:0]      jog_vel_o,
  output logic [31:0]      jog_acc_o,
  output logic [31:0]      pos_loop_res_o,
  output logic             irq_o
);
  import sam_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [31:0] smax(input logic [31:0] a,
                                       input logic [31:0] b);
    smax = ($signed(a) > $signed(b)) ? a : b;
  endfunction

  function automatic logic [31:0] smin(input logic [31:0] a,
                                       input logic [31:0] b);
    smin = ($signed(a) < $signed(b)) ? a : b;
  endfunction

  // ==========================================================
  // bus slave
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic [31:0] ctrl_q;
  logic [15:0] dly_ms_q;
  logic [31:0] gain_q;
  logic [31:0] jogv_q;
  logic [31:0] joga_q;
  logic [31:0] hilim_q;
  logic [31:0] lolim_q;
  logic [31:0] peot_q;
  logic [31:0] neot_q;
  logic [31:0] tune1_q;
  logic [31:0] tune2_q;
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] irq_en_q;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  logic [31:0] status;
  logic [31:0] rd_d;
  logic        addr_ok;
  sam_drv_state_t drv_q;

  assign addr_ok = hsel_i & hready_i & htrans_i[1];

  // capture write address phase
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (hready_i) begin
      wr_pend_q <= addr_ok & hwrite_i;
      wr_addr_q <= haddr_i[7:0];
    end
  end

  // configuration writes
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl_q   <= 32'h00000000;
      dly_ms_q <= DLY_MS_DEF;
      gain_q   <= {24'h000000, GAIN_DEF};
      jogv_q   <= JOGV_DEF;
      joga_q   <= JOGA_DEF;
      hilim_q  <= HILIM_DEF;
      lolim_q  <= LOLIM_DEF;
      peot_q   <= HILIM_DEF;
      neot_q   <= LOLIM_DEF;
      tune1_q  <= 32'h00000000;
      tune2_q  <= 32'h00000000;
      irq_en_q <= '0;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        OFF_CTRL:   ctrl_q   <= hwdata_i;
        OFF_DLY:    dly_ms_q <= hwdata_i[15:0];
        OFF_GAIN:   gain_q   <= hwdata_i;
        OFF_JOGV:   jogv_q   <= hwdata_i;
        OFF_JOGA:   joga_q   <= hwdata_i;
        OFF_HILIM:  hilim_q  <= hwdata_i;
        OFF_LOLIM:  lolim_q  <= hwdata_i;
        OFF_PEOT:   peot_q   <= hwdata_i;
        OFF_NEOT:   neot_q   <= hwdata_i;
        OFF_TUNE1:  tune1_q  <= hwdata_i;
        OFF_TUNE2:  tune2_q  <= hwdata_i;
        OFF_IRQ_EN: irq_en_q <= hwdata_i[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  assign irq_clr = (wr_pend_q && wr_addr_q == OFF_IRQ_CLR) ?
                   hwdata_i[IRQ_W-1:0] : '0;

  // ==========================================================
  // configuration decode
  logic            digital;
  logic            follow;
  sam_axis_mode_t  mode;
  logic [7:0]      sel1;
  logic [7:0]      sel2;
  logic [15:0]     dat1;
  logic [15:0]     dat2;
  logic            gain_bad;
  logic            tune_bad;
  logic            res_sel;
  logic [15:0]     res_dat;
  logic [31:0]     lim_p;
  logic [31:0]     lim_n;
  logic [31:0]     acc_eff;

  assign digital = ctrl_q[CB_DIGITAL];
  assign follow  = ctrl_q[CB_FOLLOW];
  assign mode    = sam_axis_mode_t'(ctrl_q[CB_MODE_HI:CB_MODE_LO]);
  assign sel1    = tune1_q[23:16];
  assign sel2    = tune2_q[23:16];
  assign dat1    = tune1_q[15:0];
  assign dat2    = tune2_q[15:0];

  // range checks on gain and tuning fields
  assign gain_bad = |gain_q[31:8];
  assign tune_bad = (sel1 > {2'b00, SEL1_MAX}) |
                    (|tune1_q[31:24]) | (|tune2_q[31:24]) |
                    ((sel1 == sel2) && (sel1 != 8'h00)) |
                    (res_sel && (res_dat > RES_DAT_MAX));

  // resolution selector, either slot; 0/0 means unused
  assign res_sel = (sel1 == SEL_RES) | (sel2 == SEL_RES);
  assign res_dat = (sel1 == SEL_RES) ? dat1 : dat2;

  // travel limits: follower forces rollover, linear clamps
  assign lim_p = follow ? hilim_q : smin(peot_q, hilim_q);
  assign lim_n = follow ? lolim_q : smax(neot_q, lolim_q);

  // acceleration floor in counts
  assign acc_eff = ($signed(joga_q) < $signed(ACC_FLOOR)) ?
                   ACC_FLOOR : joga_q;

  // ==========================================================
  // motion configuration outputs
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rev_comp_en_o      <= 1'b0;
      speed_loop_gain_o  <= GAIN_DEF;
      scurve_o           <= 1'b0;
      eot_check_o        <= 1'b0;
      travel_limit_pos_o <= HILIM_DEF;
      travel_limit_neg_o <= LOLIM_DEF;
      jog_vel_o          <= JOGV_DEF;
      jog_acc_o          <= JOGA_DEF;
      pos_loop_res_o     <= RES_BASE;
    end else begin
      rev_comp_en_o <= ~follow;
      // gain held at zero for analog or out-of-range values
      speed_loop_gain_o <= (digital && !gain_bad) ?
                           gain_q[7:0] : 8'h00;
      scurve_o    <= ctrl_q[CB_SCURVE];
      eot_check_o <= (mode == SAM_LINEAR);
      travel_limit_pos_o <= lim_p;
      travel_limit_neg_o <= lim_n;
      jog_vel_o <= jogv_q;
      jog_acc_o <= acc_eff;
      if (digital && res_sel && !tune_bad)
        pos_loop_res_o <= RES_BASE << res_dat[1:0];
      else
        pos_loop_res_o <= RES_BASE;
    end
  end

  // ==========================================================
  // drive-off delay: ms tick divider and counter
  logic [17:0] tick_cnt_q;
  logic        ms_tick;
  logic [15:0] ms_left_q;
  logic        stop_req;

  assign ms_tick  = (tick_cnt_q == MS_TICKS);
  assign stop_req = ~ctrl_q[CB_EN] | stop_error_i;

  // one-cycle millisecond strobe, restarted on entering hold
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      tick_cnt_q <= '0;
    else if (drv_q != SAM_HOLD || ms_tick)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + 18'h00001;
  end

  // drive enable sequencing
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      drv_q     <= SAM_OFF;
      ms_left_q <= '0;
    end else begin
      case (drv_q)
        SAM_OFF:  if (!stop_req) drv_q <= SAM_ON;
        SAM_ON:   if (stop_req) drv_q <= SAM_WAIT;
        SAM_WAIT: begin
          if (vel_zero_i) begin
            ms_left_q <= dly_ms_q;
            drv_q     <= (dly_ms_q == 16'h0000) ? SAM_OFF : SAM_HOLD;
          end
        end
        SAM_HOLD: begin
          if (ms_tick) begin
            ms_left_q <= ms_left_q - 16'h0001;
            if (ms_left_q == 16'h0001) drv_q <= SAM_OFF;
          end
        end
        default: drv_q <= SAM_OFF;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      servo_power_on_signal_o <= 1'b0;
    else
      servo_power_on_signal_o <= (drv_q != SAM_OFF);
  end

  // ==========================================================
  // events and interrupt
  logic drv_fall;
  logic cfg_bad_q;

  assign drv_fall = servo_power_on_signal_o & (drv_q == SAM_OFF);

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      cfg_bad_q <= 1'b0;
    else
      cfg_bad_q <= gain_bad | tune_bad;
  end

  always_comb begin
    irq_set = '0;
    // battery alarm only in digital absolute mode
    irq_set[IB_BATTERY]  = battery_alarm_i & digital &
                           ctrl_q[CB_ABS];
    irq_set[IB_CFGERR]   = (gain_bad | tune_bad) & ~cfg_bad_q;
    irq_set[IB_DRIVEOFF] = drv_fall;
    irq_set[IB_ROLL]     = (mode == SAM_CONTINU) &
                           (pos_wrap_hi_i | pos_wrap_lo_i);
  end

  // sticky status, set wins over clear
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      irq_st_q <= '0;
    else
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_o           <= 1'b0;
      battery_alarm_o <= 1'b0;
    end else begin
      irq_o           <= |(irq_st_q & irq_en_q);
      battery_alarm_o <= irq_set[IB_BATTERY];
    end
  end

  // ==========================================================
  // read data
  always_comb begin
    status = '0;
    status[SB_DRIVE]   = servo_power_on_signal_o;
    status[SB_REVCOMP] = rev_comp_en_o;
    status[SB_CFGERR]  = gain_bad;
    status[SB_EOTCHK]  = eot_check_o;
    status[SB_RSVMODE] = mode[1];
    status[SB_TUNEERR] = tune_bad;
  end

  always_comb begin
    case (haddr_i[7:0])
      OFF_CTRL:     rd_d = ctrl_q;
      OFF_DLY:      rd_d = {16'h0000, dly_ms_q};
      OFF_GAIN:     rd_d = gain_q;
      OFF_JOGV:     rd_d = jogv_q;
      OFF_JOGA:     rd_d = joga_q;
      OFF_HILIM:    rd_d = hilim_q;
      OFF_LOLIM:    rd_d = lolim_q;
      OFF_PEOT:     rd_d = peot_q;
      OFF_NEOT:     rd_d = neot_q;
      OFF_TUNE1:    rd_d = tune1_q;
      OFF_TUNE2:    rd_d = tune2_q;
      OFF_STATUS:   rd_d = status;
      OFF_IRQ_ST:   rd_d = {28'h0000000, irq_st_q};
      OFF_IRQ_EN:   rd_d = {28'h0000000, irq_en_q};
      OFF_EFF_PEOT: rd_d = travel_limit_pos_o;
      OFF_EFF_NEOT: rd_d = travel_limit_neg_o;
      OFF_RES:      rd_d = pos_loop_res_o;
      OFF_EFF_ACC:  rd_d = jog_acc_o;
      default:      rd_d = 32'h00000000;
    endcase
  end

  // read data registered at address phase; zero wait states
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hrdata_o    <= 32'h00000000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else if (addr_ok && !hwrite_i) begin
      hrdata_o <= rd_d;
    end
  end
endmodule

// ### core/sam_pkg.sv
package sam_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_DLY     = 8'h04;
  localparam logic [7:0] OFF_GAIN    = 8'h08;
  localparam logic [7:0] OFF_JOGV    = 8'h0c;
  localparam logic [7:0] OFF_JOGA    = 8'h10;
  localparam logic [7:0] OFF_HILIM   = 8'h14;
  localparam logic [7:0] OFF_LOLIM   = 8'h18;
  localparam logic [7:0] OFF_PEOT    = 8'h1c;
  localparam logic [7:0] OFF_NEOT    = 8'h20;
  localparam logic [7:0] OFF_TUNE1   = 8'h24;
  localparam logic [7:0] OFF_TUNE2   = 8'h28;
  localparam logic [7:0] OFF_STATUS  = 8'h2c;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h30;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h34;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h38;
  localparam logic [7:0] OFF_EFF_PEOT = 8'h3c;
  localparam logic [7:0] OFF_EFF_NEOT = 8'h40;
  localparam logic [7:0] OFF_RES     = 8'h44;
  localparam logic [7:0] OFF_EFF_ACC = 8'h48;

  // ctrl register fields
  localparam int CB_EN      = 0;
  localparam int CB_DIGITAL = 1;
  localparam int CB_ABS     = 2;
  localparam int CB_SCURVE  = 3;
  localparam int CB_FOLLOW  = 4;
  localparam int CB_MODE_LO = 5;
  localparam int CB_MODE_HI = 6;

  // status register fields
  localparam int SB_DRIVE   = 0;
  localparam int SB_REVCOMP = 1;
  localparam int SB_CFGERR  = 2;
  localparam int SB_EOTCHK  = 3;
  localparam int SB_RSVMODE = 4;
  localparam int SB_TUNEERR = 5;

  // interrupt event bits
  localparam int IRQ_W       = 4;
  localparam int IB_BATTERY  = 0;
  localparam int IB_CFGERR   = 1;
  localparam int IB_DRIVEOFF = 2;
  localparam int IB_ROLL     = 3;

  typedef enum logic [1:0] {
    SAM_CONTINU = 2'b00,
    SAM_LINEAR  = 2'b01,
    SAM_RSV_A   = 2'b10,
    SAM_RSV_B   = 2'b11
  } sam_axis_mode_t;

  typedef enum logic [1:0] {
    SAM_OFF  = 2'b00,
    SAM_ON   = 2'b01,
    SAM_WAIT = 2'b10,
    SAM_HOLD = 2'b11
  } sam_drv_state_t;

  // reset values
  localparam logic [15:0] DLY_MS_DEF   = 16'h0064;       // 100 ms
  localparam logic [7:0]  GAIN_DEF     = 8'h10;          // 16
  localparam logic [31:0] JOGV_DEF     = 32'h000003e8;   // 1000
  localparam logic [31:0] JOGA_DEF     = 32'h00002710;   // 10000
  localparam logic [31:0] HILIM_DEF    = 32'h007fffff;
  localparam logic [31:0] LOLIM_DEF    = 32'hff800000;
  localparam logic [31:0] ACC_FLOOR    = 32'h00000020;   // 32 cts/s/s
  localparam logic [5:0]  SEL1_MAX     = 6'h3f;
  localparam logic [7:0]  SEL_RES      = 8'h01;
  localparam logic [15:0] RES_DAT_MAX  = 16'h0003;
  localparam logic [31:0] RES_BASE     = 32'h00002000;   // 8192 cts/rev

  // timing: 1 ms at 250 MHz
  localparam int CLK_MHZ    = 250;
  localparam int MS_NS      = 1000000;
  localparam int CLK_NS     = 1000 / CLK_MHZ;
  localparam int MS_CYCLES  = MS_NS / CLK_NS;
  localparam logic [17:0] MS_TICKS = 18'(MS_CYCLES - 1);
endpackage
